// ===== hdl/msl_pkg.sv
// Constants shared by the meter serial link design
package msl_pkg;
	// ****************************************
	// Register map and field layout
	// ****************************************
	localparam logic [15:0] CFG_REG_ADDR = 16'h0004;
	localparam logic [15:0] ENERGY_HI_ADDR = 16'h000C;
	localparam logic [15:0] ENERGY_LO_ADDR = 16'h000D;
	localparam logic [15:0] CFG_RESET = 16'h0105;
	localparam int SLAVE_MSB = 15;
	localparam int SLAVE_LSB = 8;
	localparam int FMT_MSB = 7;
	localparam int FMT_LSB = 6;
	localparam int RATE_MSB = 5;
	localparam int RATE_LSB = 0;
	localparam logic [7:0] BROADCAST_ADDR = 8'h00;
	localparam logic [15:0] CT_RATIO_RESET = 16'h0001;
	// ****************************************
	// Character formats
	// ****************************************
	localparam logic [1:0] FMT_N81 = 2'h0;
	localparam logic [1:0] FMT_E81 = 2'h1;
	localparam logic [1:0] FMT_O81 = 2'h2;
	localparam logic [1:0] FMT_N82 = 2'h3;
	// ****************************************
	// Rate codes (low six bits of config)
	// ****************************************
	localparam logic [5:0] RATE_1200 = 6'h02;
	localparam logic [5:0] RATE_2400 = 6'h03;
	localparam logic [5:0] RATE_4800 = 6'h04;
	localparam logic [5:0] RATE_9600 = 6'h05;
	// ****************************************
	// Protocol
	// ****************************************
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_WRITE = 8'h10;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned BASE_BAUD = 9600;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned OS_DIV = CLK_HZ / (BASE_BAUD * OVERSAMPLE);
	localparam int unsigned GAP_BITS = 39;
	localparam int unsigned GAP_TICKS = GAP_BITS * OVERSAMPLE;
	localparam int unsigned REFRESH_MS = 1000;
	localparam int unsigned REFRESH_CYCLES = (CLK_HZ / 1000) * REFRESH_MS;
endpackage : msl_pkg

// ===== hdl/msl_if.sv
// Byte stream carrier between the frame core and the serial engine
`timescale 1ns/1ps
interface msl_if;
	logic [1:0] fmt;
	logic os_tick;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_err;
	logic rx_busy;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_ready;
	logic tx_busy;
	modport core (output fmt, os_tick, tx_valid, tx_data,
		input rx_valid, rx_data, rx_err, rx_busy, tx_ready, tx_busy);
	modport engine (input fmt, os_tick, tx_valid, tx_data,
		output rx_valid, rx_data, rx_err, rx_busy, tx_ready, tx_busy);
endinterface : msl_if

// ===== hdl/msl_uart.sv
// Serial character engine: 16x oversampled receiver and transmitter
`timescale 1ns/1ps
module msl_uart (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Line
	input wire logic rxd,
	output logic txd,
	// Core side
	msl_if.engine port
);
	typedef enum logic {MU_IDLE, MU_RUN} msl_ph_t;
	msl_ph_t rx_st_q, rx_st_d, tx_st_q, tx_st_d;
	logic [3:0] rx_os_q, rx_os_d, rx_bit_q, rx_bit_d;
	logic [3:0] tx_os_q, tx_os_d, tx_bit_q, tx_bit_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic rx_err_q, rx_err_d, rx_vld_q, rx_vld_d;
	logic [11:0] tx_sh_q, tx_sh_d;
	logic txd_q, txd_d;
	logic par_en, par_odd;
	logic [3:0] nbits;

	assign par_en = (port.fmt == msl_pkg::FMT_E81) ||
		(port.fmt == msl_pkg::FMT_O81);
	assign par_odd = (port.fmt == msl_pkg::FMT_O81);
	assign nbits = (port.fmt == msl_pkg::FMT_N81) ? 4'hA : 4'hB;
	assign port.rx_busy = (rx_st_q == MU_RUN);
	assign port.rx_valid = rx_vld_q;
	assign port.rx_data = rx_sh_q;
	assign port.rx_err = rx_err_q;
	assign port.tx_ready = (tx_st_q == MU_IDLE);
	assign port.tx_busy = (tx_st_q == MU_RUN);
	assign txd = txd_q;

	// ****************************************
	// Receiver
	// ****************************************
	always_comb begin
		rx_st_d = rx_st_q;
		rx_os_d = rx_os_q;
		rx_bit_d = rx_bit_q;
		rx_sh_d = rx_sh_q;
		rx_err_d = rx_err_q;
		rx_vld_d = 1'b0;
		case (rx_st_q)
			MU_IDLE: begin
				if (port.os_tick && !rxd) begin
					rx_st_d = MU_RUN;
					rx_os_d = 4'h1;
					rx_bit_d = 4'h0;
					rx_err_d = 1'b0;
				end
			end
			MU_RUN: begin
				if (port.os_tick) begin
					rx_os_d = rx_os_q + 4'h1;
					// Mid-bit sample
					if (rx_os_q == 4'h7) begin
						rx_bit_d = rx_bit_q + 4'h1;
						if (rx_bit_q == 4'h0) begin
							// Glitch, not a start bit
							if (rxd) begin
								rx_st_d = MU_IDLE;
							end
						end else if (rx_bit_q <= 4'h8) begin
							rx_sh_d = {rxd, rx_sh_q[7:1]};
						end else if (rx_bit_q == 4'h9 && par_en) begin
							if (rxd != ((^rx_sh_q) ^ par_odd)) begin
								rx_err_d = 1'b1;
							end
						end else if (!rxd) begin
							rx_err_d = 1'b1;
						end
						if (rx_bit_q == nbits - 4'h1) begin
							rx_st_d = MU_IDLE;
							rx_vld_d = 1'b1;
						end
					end
				end
			end
			default: rx_st_d = MU_IDLE;
		endcase
	end

	// ****************************************
	// Transmitter
	// ****************************************
	always_comb begin
		tx_st_d = tx_st_q;
		tx_os_d = tx_os_q;
		tx_bit_d = tx_bit_q;
		tx_sh_d = tx_sh_q;
		txd_d = txd_q;
		case (tx_st_q)
			MU_IDLE: begin
				txd_d = 1'b1;
				if (port.tx_valid) begin
					tx_st_d = MU_RUN;
					tx_os_d = 4'h0;
					tx_bit_d = 4'h0;
					tx_sh_d = {2'b11, par_en ? ((^port.tx_data) ^ par_odd)
						: 1'b1, port.tx_data, 1'b0};
				end
			end
			MU_RUN: begin
				txd_d = tx_sh_q[0];
				if (port.os_tick) begin
					tx_os_d = tx_os_q + 4'h1;
					if (tx_os_q == 4'hF) begin
						tx_sh_d = {1'b1, tx_sh_q[11:1]};
						tx_bit_d = tx_bit_q + 4'h1;
						if (tx_bit_q == nbits - 4'h1) begin
							tx_st_d = MU_IDLE;
						end
					end
				end
			end
			default: tx_st_d = MU_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_st_q <= MU_IDLE;
			rx_os_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_err_q <= 1'b0;
			rx_vld_q <= 1'b0;
			tx_st_q <= MU_IDLE;
			tx_os_q <= 4'h0;
			tx_bit_q <= 4'h0;
			tx_sh_q <= 12'hFFF;
			txd_q <= 1'b1;
		end else begin
			rx_st_q <= rx_st_d;
			rx_os_q <= rx_os_d;
			rx_bit_q <= rx_bit_d;
			rx_sh_q <= rx_sh_d;
			rx_err_q <= rx_err_d;
			rx_vld_q <= rx_vld_d;
			tx_st_q <= tx_st_d;
			tx_os_q <= tx_os_d;
			tx_bit_q <= tx_bit_d;
			tx_sh_q <= tx_sh_d;
			txd_q <= txd_d;
		end
	end
endmodule : msl_uart

// ===== hdl/msl_top.sv
// Modbus-RTU slave link of the energy meter, with config and energy count
// Notes on behaviour
// - Formats n81, e81, o81 and n82, always eight data bits.
// - Rates 1200, 2400, 4800, 9600 shared by receiver and transmitter.
// - Ships as address 1, 9600, n81, 1000 ms refresh, ratio one.
// - Energy is 32-bit unsigned, restorable after power loss, no early wrap.
// - Config register at word 0004H, read and write, resets to 0105H.
// - Config high byte is own slave address, unicast 1 through 255.
// - Address zero is broadcast, never an individual device.
// - Low byte top two bits select format 00 n81 to 11 n82.
// - Energy pulse output idles low, pulses with active energy.
// - Indicator lit when powered, blinks during serial traffic.
// - Frame is address, function, data, then CRC16 low byte first.
// - Any received error means no reply.
// - Reply only to own address; otherwise line stays idle.
// - Config read with 03H and written with 10H.
`timescale 1ns/1ps
module msl_top #(
	parameter int unsigned REFRESH_CYCLES = msl_pkg::REFRESH_CYCLES,
	// Lowered only in simulation, to keep serial runs short
	parameter int unsigned OS_DIV = msl_pkg::OS_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Serial line
	input wire logic rxd,
	output logic txd,
	// Energy
	input wire logic energy_tick_in,
	input wire logic energy_restore_en,
	input wire logic [31:0] energy_restore_val,
	output logic [31:0] energy_count,
	output logic energy_pulse_out,
	// Status
	output logic activity_led,
	output logic refresh_tick,
	output logic [15:0] ct_ratio,
	output logic [15:0] cfg_value
);
	typedef enum logic [1:0] {MS_RX, MS_TX, MS_DONE} msl_state_t;
	msl_if lnk();

	msl_state_t st_q, st_d;
	logic [15:0] cfg_q, cfg_d, pend_q, pend_d;
	logic pend_v_q, pend_v_d;
	logic [31:0] en_q, en_d;
	logic [9:0] div_q, div_d, gap_q, gap_d;
	logic [2:0] pre_q, pre_d, shift;
	logic [31:0] rf_q, rf_d;
	logic rf_tick_q, rf_tick_d, pulse_q, pulse_d, led_q, led_d;
	logic [3:0] idx_q, idx_d, ti_q, ti_d, len_q, len_d;
	logic err_q, err_d;
	logic [15:0] crc_q, crc_d;
	logic [7:0] f_adr_q, f_adr_d, f_fc_q, f_fc_d, f_bc_q, f_bc_d;
	logic [15:0] f_st_q, f_st_d, f_qt_q, f_qt_d;
	logic [31:0] f_dat_q, f_dat_d;
	logic base_tick, os_tick, rd_ok, wr_cfg, wr_en, own, frame_ok;
	logic [7:0] tx_byte, own_adr;
	logic [15:0] rd_word, rd_adr;

	msl_uart u_uart (
		.clk(clk),
		.reset_n(reset_n),
		.rxd(rxd),
		.txd(txd),
		.port(lnk.engine)
	);

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ msl_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte

	// ****************************************
	// Rate generation
	// ****************************************
	always_comb begin
		case (cfg_q[msl_pkg::RATE_MSB:msl_pkg::RATE_LSB])
			msl_pkg::RATE_1200: shift = 3'h3;
			msl_pkg::RATE_2400: shift = 3'h2;
			msl_pkg::RATE_4800: shift = 3'h1;
			// Unknown codes fall back to the fastest rate
			default: shift = 3'h0;
		endcase
	end
	assign base_tick = (div_q == 10'(OS_DIV - 1));
	assign os_tick = base_tick &&
		((pre_q & 3'((4'h1 << shift) - 4'h1)) == 3'h0);
	assign lnk.os_tick = os_tick;
	assign lnk.fmt = cfg_q[msl_pkg::FMT_MSB:msl_pkg::FMT_LSB];

	// ****************************************
	// Request checks
	// ****************************************
	assign own_adr = cfg_q[msl_pkg::SLAVE_MSB:msl_pkg::SLAVE_LSB];
	assign own = (f_adr_q == own_adr);
	assign rd_ok = (f_fc_q == msl_pkg::FC_READ) && (idx_q == 4'h8) &&
		(((f_st_q == msl_pkg::CFG_REG_ADDR) && (f_qt_q == 16'h0001)) ||
		((f_st_q == msl_pkg::ENERGY_HI_ADDR) && (f_qt_q == 16'h0001 ||
		f_qt_q == 16'h0002)) || ((f_st_q == msl_pkg::ENERGY_LO_ADDR) &&
		(f_qt_q == 16'h0001)));
	assign wr_cfg = (f_fc_q == msl_pkg::FC_WRITE) && (idx_q == 4'hB) &&
		(f_st_q == msl_pkg::CFG_REG_ADDR) && (f_qt_q == 16'h0001) &&
		(f_bc_q == 8'h02) &&
		(f_dat_q[31:24] != msl_pkg::BROADCAST_ADDR);
	assign wr_en = (f_fc_q == msl_pkg::FC_WRITE) && (idx_q == 4'hD) &&
		(f_st_q == msl_pkg::ENERGY_HI_ADDR) && (f_qt_q == 16'h0002) &&
		(f_bc_q == 8'h04);
	assign frame_ok = !err_q && (crc_q == 16'h0000) &&
		(own || f_adr_q == msl_pkg::BROADCAST_ADDR) &&
		(rd_ok || wr_cfg || wr_en);

	// ****************************************
	// Reply bytes
	// ****************************************
	always_comb begin
		rd_adr = f_st_q + 16'({12'h000, ti_q - 4'h3} >> 1);
		case (rd_adr)
			msl_pkg::CFG_REG_ADDR: rd_word = cfg_q;
			msl_pkg::ENERGY_HI_ADDR: rd_word = en_q[31:16];
			default: rd_word = en_q[15:0];
		endcase
		if (ti_q == len_q - 4'h2) begin
			tx_byte = crc_q[7:0];
		end else if (ti_q == len_q - 4'h1) begin
			tx_byte = crc_q[15:8];
		end else if (ti_q == 4'h0) begin
			tx_byte = own_adr;
		end else if (ti_q == 4'h1) begin
			tx_byte = f_fc_q;
		end else if (f_fc_q == msl_pkg::FC_WRITE) begin
			case (ti_q)
				4'h2: tx_byte = f_st_q[15:8];
				4'h3: tx_byte = f_st_q[7:0];
				4'h4: tx_byte = f_qt_q[15:8];
				default: tx_byte = f_qt_q[7:0];
			endcase
		end else if (ti_q == 4'h2) begin
			tx_byte = {f_qt_q[6:0], 1'b0};
		end else begin
			tx_byte = ti_q[0] ? rd_word[15:8] : rd_word[7:0];
		end
	end
	assign lnk.tx_valid = (st_q == MS_TX) && (ti_q != len_q);
	assign lnk.tx_data = tx_byte;

	// ****************************************
	// Frame engine and registers
	// ****************************************
	always_comb begin
		st_d = st_q;
		cfg_d = cfg_q;
		pend_d = pend_q;
		pend_v_d = pend_v_q;
		en_d = en_q;
		idx_d = idx_q;
		ti_d = ti_q;
		len_d = len_q;
		err_d = err_q;
		crc_d = crc_q;
		f_adr_d = f_adr_q;
		f_fc_d = f_fc_q;
		f_bc_d = f_bc_q;
		f_st_d = f_st_q;
		f_qt_d = f_qt_q;
		f_dat_d = f_dat_q;
		gap_d = gap_q;
		if (energy_tick_in) begin
			en_d = en_q + 32'h0000_0001;
		end
		case (st_q)
			MS_RX: begin
				if (lnk.rx_busy) begin
					gap_d = 10'h000;
				end else if (os_tick && gap_q != 10'(msl_pkg::GAP_TICKS)) begin
					gap_d = gap_q + 10'h001;
				end
				if (lnk.rx_valid) begin
					crc_d = crc_byte(crc_q, lnk.rx_data);
					err_d = err_q || lnk.rx_err || (idx_q == 4'hF);
					if (idx_q != 4'hF) begin
						idx_d = idx_q + 4'h1;
					end
					case (idx_q)
						4'h0: f_adr_d = lnk.rx_data;
						4'h1: f_fc_d = lnk.rx_data;
						4'h2: f_st_d[15:8] = lnk.rx_data;
						4'h3: f_st_d[7:0] = lnk.rx_data;
						4'h4: f_qt_d[15:8] = lnk.rx_data;
						4'h5: f_qt_d[7:0] = lnk.rx_data;
						4'h6: f_bc_d = lnk.rx_data;
						4'h7: f_dat_d[31:24] = lnk.rx_data;
						4'h8: f_dat_d[23:16] = lnk.rx_data;
						4'h9: f_dat_d[15:8] = lnk.rx_data;
						4'hA: f_dat_d[7:0] = lnk.rx_data;
						default: ;
					endcase
				end else if (gap_q == 10'(msl_pkg::GAP_TICKS) &&
					idx_q != 4'h0) begin
					idx_d = 4'h0;
					err_d = 1'b0;
					crc_d = msl_pkg::CRC_INIT;
					if (frame_ok) begin
						if (wr_en) begin
							en_d = f_dat_q;
						end
						if (wr_cfg && !own) begin
							cfg_d = f_dat_q[31:16];
						end else if (wr_cfg) begin
							pend_d = f_dat_q[31:16];
							pend_v_d = 1'b1;
						end
						if (own) begin
							st_d = MS_TX;
							ti_d = 4'h0;
							len_d = rd_ok ? 4'(5 + 2 * f_qt_q) : 4'h8;
						end
					end
				end
			end
			MS_TX: begin
				if (lnk.tx_valid && lnk.tx_ready) begin
					ti_d = ti_q + 4'h1;
					if (ti_q < len_q - 4'h2) begin
						crc_d = crc_byte(crc_q, tx_byte);
					end
				end else if (ti_q == len_q) begin
					st_d = MS_DONE;
				end
			end
			MS_DONE: begin
				// Wait for the last stop bit to leave the pin
				if (!lnk.tx_busy) begin
					if (pend_v_q) begin
						cfg_d = pend_q;
					end
					pend_v_d = 1'b0;
					crc_d = msl_pkg::CRC_INIT;
					gap_d = 10'h000;
					st_d = MS_RX;
				end
			end
			default: st_d = MS_RX;
		endcase
		if (energy_restore_en) begin
			en_d = energy_restore_val;
		end
	end

	// ****************************************
	// Dividers, pulse and indicator
	// ****************************************
	always_comb begin
		div_d = base_tick ? 10'h000 : div_q + 10'h001;
		pre_d = base_tick ? pre_q + 3'h1 : pre_q;
		rf_tick_d = (rf_q == REFRESH_CYCLES - 1);
		rf_d = rf_tick_d ? 32'h0000_0000 : rf_q + 32'h0000_0001;
		pulse_d = energy_tick_in;
		led_d = !(lnk.rx_busy || lnk.tx_busy);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_q <= MS_RX;
			cfg_q <= msl_pkg::CFG_RESET;
			pend_q <= msl_pkg::CFG_RESET;
			pend_v_q <= 1'b0;
			en_q <= 32'h0000_0000;
			idx_q <= 4'h0;
			ti_q <= 4'h0;
			len_q <= 4'h8;
			err_q <= 1'b0;
			crc_q <= msl_pkg::CRC_INIT;
			f_adr_q <= 8'h00;
			f_fc_q <= 8'h00;
			f_bc_q <= 8'h00;
			f_st_q <= 16'h0000;
			f_qt_q <= 16'h0000;
			f_dat_q <= 32'h0000_0000;
			gap_q <= 10'h000;
			div_q <= 10'h000;
			pre_q <= 3'h0;
			rf_q <= 32'h0000_0000;
			rf_tick_q <= 1'b0;
			pulse_q <= 1'b0;
			led_q <= 1'b1;
		end else begin
			st_q <= st_d;
			cfg_q <= cfg_d;
			pend_q <= pend_d;
			pend_v_q <= pend_v_d;
			en_q <= en_d;
			idx_q <= idx_d;
			ti_q <= ti_d;
			len_q <= len_d;
			err_q <= err_d;
			crc_q <= crc_d;
			f_adr_q <= f_adr_d;
			f_fc_q <= f_fc_d;
			f_bc_q <= f_bc_d;
			f_st_q <= f_st_d;
			f_qt_q <= f_qt_d;
			f_dat_q <= f_dat_d;
			gap_q <= gap_d;
			div_q <= div_d;
			pre_q <= pre_d;
			rf_q <= rf_d;
			rf_tick_q <= rf_tick_d;
			pulse_q <= pulse_d;
			led_q <= led_d;
		end
	end

	assign energy_count = en_q;
	assign energy_pulse_out = pulse_q;
	assign activity_led = led_q;
	assign refresh_tick = rf_tick_q;
	assign ct_ratio = msl_pkg::CT_RATIO_RESET;
	assign cfg_value = cfg_q;
endmodule : msl_top

// ===== tb/msl_chk.sv
// Port checker for the meter serial link top, bound to msl_top
`timescale 1ns/1ps
module msl_chk #(
	parameter int unsigned REFRESH_CYCLES = 100,
	parameter int unsigned OS_DIV = msl_pkg::OS_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Serial line
	input wire logic rxd,
	input wire logic txd,
	// Energy
	input wire logic energy_tick_in,
	input wire logic energy_restore_en,
	input wire logic [31:0] energy_restore_val,
	input wire logic [31:0] energy_count,
	input wire logic energy_pulse_out,
	// Status
	input wire logic activity_led,
	input wire logic refresh_tick,
	input wire logic [15:0] ct_ratio,
	input wire logic [15:0] cfg_value
);
	localparam int unsigned BITC = OS_DIV * msl_pkg::OVERSAMPLE;
	// ****************************************
	// Helper counters
	// ****************************************
	logic [31:0] quiet_q, quiet_d, per_q, per_d;
	logic seen_q, seen_d;
	always_comb begin
		quiet_d = rxd ? quiet_q + 32'h1 : 32'h0;
		per_d = refresh_tick ? 32'h0 : per_q + 32'h1;
		seen_d = seen_q | refresh_tick;
		if (!reset_n) begin
			quiet_d = 32'h0;
			per_d = 32'h0;
			seen_d = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		quiet_q <= quiet_d;
		per_q <= per_d;
		seen_q <= seen_d;
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_count;
		energy_tick_in && !energy_restore_en;
	endsequence
	sequence s_restore;
		energy_restore_en;
	endsequence
	reset_vals_a: assert property (disable iff (1'b0) !reset_n |=>
		cfg_value == 16'h0105 && txd && !energy_pulse_out && activity_led)
		else $error("reset values wrong");
	pulse_follow_a: assert property (1'b1 |=>
		energy_pulse_out == $past(energy_tick_in))
		else $error("energy pulse does not follow tick");
	count_incr_a: assert property (s_count |=>
		energy_count == $past(energy_count) + 32'h1)
		else $error("energy count did not step");
	count_load_a: assert property (s_restore |=>
		energy_count == $past(energy_restore_val))
		else $error("energy restore not loaded");
	ratio_one_a: assert property (ct_ratio == 16'h0001)
		else $error("ratio not one");
	refresh_period_a: assert property (refresh_tick && seen_q |->
		per_q == REFRESH_CYCLES - 1)
		else $error("refresh period wrong");
	refresh_miss_a: assert property (seen_q |-> per_q < REFRESH_CYCLES)
		else $error("refresh tick missing");
	reply_gap_a: assert property ($fell(txd) |-> quiet_q >= 38 * BITC)
		else $error("reply started without frame gap");
	led_rx_a: assert property ($fell(rxd) |-> ##[1:1000] !activity_led)
		else $error("indicator did not blink on receive");
	led_tx_a: assert property ($fell(txd) |-> ##[0:4] !activity_led)
		else $error("indicator did not blink on send");
	cfg_apply_a: assert property ($changed(cfg_value) |-> txd)
		else $error("config changed while sending");
endmodule : msl_chk

bind msl_top msl_chk #(.REFRESH_CYCLES(REFRESH_CYCLES), .OS_DIV(OS_DIV))
	u_chk (
	.clk(clk), .reset_n(reset_n), .rxd(rxd), .txd(txd),
	.energy_tick_in(energy_tick_in), .energy_restore_en(energy_restore_en),
	.energy_restore_val(energy_restore_val), .energy_count(energy_count),
	.energy_pulse_out(energy_pulse_out), .activity_led(activity_led),
	.refresh_tick(refresh_tick), .ct_ratio(ct_ratio), .cfg_value(cfg_value)
);

// ===== tb/msl_master_model.sv
// Bus master model: serial character sender and receiver
`timescale 1ns/1ps
module msl_master_model #(
	parameter int BITC = 16
) (
	// Clock
	input wire logic clk,
	// Line
	output logic rxd,
	input wire logic txd
);
	logic [1:0] fmt;
	initial begin
		rxd = 1'b1;
		fmt = 2'h0;
	end
	task automatic put_byte(input logic [7:0] b);
		logic [10:0] w;
		logic par;
		par = (fmt[0] ^ fmt[1]) ? (^b ^ fmt[1]) : 1'b1;
		w = {1'b1, par, b, 1'b0};
		@(posedge clk);
		for (int i = 0; i < 11; i++) begin
			rxd <= w[i];
			repeat (BITC) @(posedge clk);
		end
	endtask : put_byte
	// Samples at falling edges, away from the design's update edge
	task automatic get_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (txd !== 1'b0 && n < 60 * BITC) begin
			@(negedge clk);
			n++;
		end
		if (txd !== 1'b0) return;
		repeat (BITC / 2) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BITC) @(negedge clk);
			b[i] = txd;
		end
		ok = 1'b1;
		if (fmt[0] ^ fmt[1]) begin
			repeat (BITC) @(negedge clk);
			ok = (txd === (^b ^ fmt[1]));
		end
		repeat (BITC) @(negedge clk);
		ok = ok && txd === 1'b1;
		if (fmt == 2'h3) begin
			repeat (BITC) @(negedge clk);
			ok = ok && txd === 1'b1;
		end
	endtask : get_byte
endmodule : msl_master_model

// ===== tb/msl_top_bench.sv
// Self-checking bench for the meter serial link top
`timescale 1ns/1ps
module msl_top_bench;
	// Fast divider: every clock is an oversample tick, 16 clocks a bit
	localparam int SIM_DIV = 1;
	localparam int BITC = SIM_DIV * msl_pkg::OVERSAMPLE;
	logic clk, reset_n, rxd, txd, energy_tick_in, energy_restore_en;
	logic energy_pulse_out, activity_led, refresh_tick;
	logic [31:0] energy_restore_val, energy_count;
	logic [15:0] ct_ratio, cfg_value, v;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	initial clk = 1'b0;
	always #4 clk = ~clk;
	msl_top #(.REFRESH_CYCLES(100), .OS_DIV(SIM_DIV)) uut (.clk(clk),
		.reset_n(reset_n),
		.rxd(rxd), .txd(txd), .energy_tick_in(energy_tick_in),
		.energy_restore_en(energy_restore_en),
		.energy_restore_val(energy_restore_val), .energy_count(energy_count),
		.energy_pulse_out(energy_pulse_out), .activity_led(activity_led),
		.refresh_tick(refresh_tick), .ct_ratio(ct_ratio),
		.cfg_value(cfg_value));
	msl_master_model #(.BITC(BITC)) m (.clk(clk), .rxd(rxd), .txd(txd));
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = msl_pkg::CRC_INIT;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ msl_pkg::CRC_POLY : c >> 1;
		end
		return c;
	endfunction : crc16
	task automatic send(input logic [7:0] q[$], input logic bad);
		logic [15:0] c;
		c = crc16(q) ^ {15'h0, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) m.put_byte(q[i]);
	endtask : send
	task automatic rd(input logic [7:0] a);
		send('{a, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01}, 1'b0);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		send('{a, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, d[15:8], d[7:0]},
			1'b0);
	endtask : wr
	task automatic expect_reply(input logic [7:0] q[$]);
		logic [15:0] c;
		logic [7:0] b;
		logic ok;
		c = crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) begin
			m.get_byte(b, ok);
			check("reply framing", ok, 1);
			check("reply byte", b, q[i]);
		end
		repeat (45 * BITC) @(posedge clk);
	endtask : expect_reply
	task automatic expect_none();
		logic [7:0] b;
		logic ok;
		m.get_byte(b, ok);
		check("silence", ok, 0);
	endtask : expect_none
	task automatic results();
		$display("Checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	// Whole run is about 61k cycles with the fast divider
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90_000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		reset_n = 1'b0;
		energy_tick_in = 1'b0;
		energy_restore_en = 1'b0;
		energy_restore_val = 32'h0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		check("cfg reset", cfg_value, 16'h0105);
		check("line idle", txd, 1);
		check("led lit", activity_led, 1);
		check("pulse idle", energy_pulse_out, 0);
		check("ratio", ct_ratio, 1);
		@(posedge clk);
		energy_restore_val <= 32'hFFFF_FFFE;
		energy_restore_en <= 1'b1;
		@(posedge clk);
		energy_restore_en <= 1'b0;
		energy_tick_in <= 1'b1;
		@(posedge clk);
		energy_tick_in <= 1'b0;
		@(negedge clk);
		check("energy count", energy_count, 32'hFFFF_FFFF);
		check("energy pulse", energy_pulse_out, 1);
		@(negedge clk);
		check("pulse end", energy_pulse_out, 0);
		$display("Test reset and energy done");
		rd(8'h01);
		expect_reply('{8'h01, 8'h03, 8'h02, 8'h01, 8'h05});
		rd(8'h02);
		expect_none();
		send('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01}, 1'b1);
		expect_none();
		$display("Test read and refusals done");
		for (int f = 1; f < 4; f++) begin
			v = {8'h01, f[1:0], 6'h05};
			wr(8'h01, v);
			expect_reply('{8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01});
			check("cfg written", cfg_value, v);
			m.fmt = f[1:0];
			rd(8'h01);
			expect_reply('{8'h01, 8'h03, 8'h02, v[15:8], v[7:0]});
		end
		$display("Test formats done");
		wr(8'h01, 16'hFFC5);
		expect_reply('{8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01});
		rd(8'h01);
		expect_none();
		rd(8'hFF);
		expect_reply('{8'hFF, 8'h03, 8'h02, 8'hFF, 8'hC5});
		wr(8'h00, 16'h0105);
		expect_none();
		check("broadcast cfg", cfg_value, 16'h0105);
		m.fmt = 2'h0;
		rd(8'h01);
		expect_reply('{8'h01, 8'h03, 8'h02, 8'h01, 8'h05});
		$display("Test address and broadcast done");
		send('{8'h01, 8'h10, 8'h00, 8'h0C, 8'h00, 8'h02, 8'h04, 8'h12,
			8'h34, 8'h56, 8'h78}, 1'b0);
		expect_reply('{8'h01, 8'h10, 8'h00, 8'h0C, 8'h00, 8'h02});
		check("energy written", energy_count, 32'h1234_5678);
		send('{8'h01, 8'h03, 8'h00, 8'h0C, 8'h00, 8'h02}, 1'b0);
		expect_reply('{8'h01, 8'h03, 8'h04, 8'h12, 8'h34, 8'h56,
			8'h78});
		$display("Test energy register done");
		results();
	end
endmodule : msl_top_bench
